// ### common/trip_event_pkg.sv
/*
 Package for the trip clear and event trigger block: register offsets, field positions,
 reset values and event-source encodings.
 Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
*/
package trip_event_pkg;

   // Register byte offsets.
   localparam logic [7:0] off_trip_flag_status = 8'h00;
   localparam logic [7:0] off_trip_flag_clear = 8'h04;
   localparam logic [7:0] off_trip_software_force = 8'h08;
   localparam logic [7:0] off_event_trigger_select = 8'h0c;
   localparam logic [7:0] off_event_prescale = 8'h10;

   // Trip flag, clear and force bit positions.
   localparam int bit_one_shot_trip = 2;
   localparam int bit_cycle_by_cycle_trip = 1;
   localparam int bit_trip_int = 0;

   // Event trigger select field positions.
   localparam int bit_conv_start_b_enable = 15;
   localparam int lsb_conv_start_b_source = 12;
   localparam int bit_conv_start_a_enable = 11;
   localparam int lsb_conv_start_a_source = 8;
   localparam int bit_module_irq_enable = 3;
   localparam int lsb_module_irq_source = 0;

   // Event prescale field positions.
   localparam int lsb_conv_start_b_event_count = 14;
   localparam int lsb_conv_start_b_event_period = 12;
   localparam int lsb_conv_start_a_event_count = 10;
   localparam int lsb_conv_start_a_event_period = 8;

   // Reset values.
   localparam logic [15:0] rst_event_trigger_select = 16'h0000;
   localparam logic [3:0] rst_event_prescale = 4'h0;
   localparam logic [31:0] rst_read_data = 32'h0000_0000;

   // Shared event-source encoding; 000 and 011 select nothing.
   typedef enum logic [2:0] {
      src_none0 = 3'h0,
      src_zero = 3'h1,
      src_period = 3'h2,
      src_none3 = 3'h3,
      src_match_a_up = 3'h4,
      src_match_a_down = 3'h5,
      src_match_b_up = 3'h6,
      src_match_b_down = 3'h7
   } event_source_type;

   // AHB transfer type and response.
   localparam logic [1:0] htrans_nonseq = 2'h2;
   localparam logic [1:0] hresp_okay = 2'h0;

endpackage

// ### rtl/trip_event_ctrl.sv
/*
 Trip flag clear/force and event trigger selection for one pulse-width-modulator module.
 Assumes an AHB-Lite master on hclk, and time-base events supplied as one-cycle pulses
 by the time-base and compare logic outside, all synchronous to hclk.
*/
// Added by the designer: the register offsets and the AHB-Lite slave port.
// Operation
// - Writing one to clear bit 2 clears the one-shot trip flag.
// - Writing one to clear bit 1 clears the cycle-by-cycle trip flag.
// - Clear register command bits always read zero.
// - Writing one to clear bit 0 clears the trip interrupt flag.
// - No trip interrupt pulse while the trip interrupt flag is set.
// - Clearing interrupt flag while a trip flag is set gives a new pulse.
// - All flags clear means no pulse until a trip flag sets again.
// - Writing one to force bit 2 sets the one-shot trip flag.
// - Writing one to force bit 1 sets the cycle-by-cycle trip flag.
// - Force zero writes are ignored; force bits read zero.
// - Select bit 15 gates converter start B pulse.
// - Select bits 14:12 choose converter start B source event.
// - Select bit 11 gates converter start A pulse.
// - Select bits 10:8 choose converter start A source event.
// - Select bit 3 enables the module interrupt.
// - Select bits 2:0 choose the module interrupt source event.
// - Cycle-by-cycle trip releases only at counter zero with trip input gone.
// - Two-bit period counts events, pulses on count reached, 00 disables.
`timescale 1ns/1ns
module trip_event_ctrl
   import trip_event_pkg::*;
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic [1:0] hresp,
   // Trip inputs, already qualified.
   input wire logic one_shot_trip_in,
   input wire logic cycle_by_cycle_trip_in,
   // Time-base events, one-cycle pulses.
   input wire logic time_base_count_zero,
   input wire logic time_base_count_period,
   input wire logic compare_a_up,
   input wire logic compare_a_down,
   input wire logic compare_b_up,
   input wire logic compare_b_down,
   // Outputs to the interrupt expander and converter.
   output logic trip_irq,
   output logic module_irq,
   output logic conv_start_a_pulse,
   output logic conv_start_b_pulse,
   output logic one_shot_trip,
   output logic cycle_by_cycle_trip_active
);
   import trip_event_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus address phase capture.

   logic wr_pend, next_wr_pend;
   logic [7:0] wr_addr, next_wr_addr;
   logic [31:0] next_hrdata;
   logic addr_phase;
   logic write_clear, write_force, write_select, write_prescale;

   assign addr_phase = hsel && hready && (htrans == htrans_nonseq);
   assign hreadyout = 1'b1;
   assign hresp = hresp_okay;

   // Writes commit in the data phase, when hwdata is valid.
   assign write_clear = wr_pend && (wr_addr == off_trip_flag_clear);
   assign write_force = wr_pend && (wr_addr == off_trip_software_force);
   assign write_select = wr_pend && (wr_addr == off_event_trigger_select);
   assign write_prescale = wr_pend && (wr_addr == off_event_prescale);

   ////////////////////////////////////////////////////////////////////////////////
   // Register state.

   logic [15:0] event_trigger_select, next_event_trigger_select;
   logic [1:0] period_a, next_period_a, period_b, next_period_b;
   logic [1:0] count_a, next_count_a, count_b, next_count_b;
   logic flag_one_shot, next_flag_one_shot;
   logic flag_cycle, next_flag_cycle;
   logic flag_int, next_flag_int;
   logic cycle_latch, next_cycle_latch;
   logic next_trip_irq, next_module_irq, next_conv_a, next_conv_b;
   logic [5:0] tb_events;
   logic ev_int, ev_a, ev_b;
   logic set_one_shot, set_cycle, clr_one_shot, clr_cycle, clr_int;

   ////////////////////////////////////////////////////////////////////////////////
   // Event source selection.

   // Gathers the six time-base events in the order of the shared encoding.
   assign tb_events = {compare_b_down, compare_b_up, compare_a_down, compare_a_up,
      time_base_count_period, time_base_count_zero};

   // Decodes the shared event encoding; reserved codes give no event.
   // The events come in as an argument, so that each caller is re-evaluated
   // whenever an event changes and not only when the selection does.
   function automatic logic pick_event(input logic [2:0] sel, input logic [5:0] evs);
      case (event_source_type'(sel))
         src_zero: pick_event = evs[0];
         src_period: pick_event = evs[1];
         src_match_a_up: pick_event = evs[2];
         src_match_a_down: pick_event = evs[3];
         src_match_b_up: pick_event = evs[4];
         src_match_b_down: pick_event = evs[5];
         default: pick_event = 1'b0;
      endcase
   endfunction

   // One selector for each of the three event consumers.
   assign ev_b = pick_event(event_trigger_select[lsb_conv_start_b_source +: 3],
      tb_events);
   assign ev_a = pick_event(event_trigger_select[lsb_conv_start_a_source +: 3],
      tb_events);
   assign ev_int = pick_event(event_trigger_select[lsb_module_irq_source +: 3],
      tb_events);

   ////////////////////////////////////////////////////////////////////////////////
   // Trip set and clear commands.

   // A hardware trip and a software force have the same effect on the flags.
   assign set_one_shot = one_shot_trip_in
      || (write_force && hwdata[bit_one_shot_trip]);
   assign set_cycle = cycle_by_cycle_trip_in
      || (write_force && hwdata[bit_cycle_by_cycle_trip]);

   // Only bits written as one act; zero bits of the same word leave flags alone.
   assign clr_one_shot = write_clear && hwdata[bit_one_shot_trip];
   assign clr_cycle = write_clear && hwdata[bit_cycle_by_cycle_trip];
   assign clr_int = write_clear && hwdata[bit_trip_int];

   ////////////////////////////////////////////////////////////////////////////////
   // Bus data phase and read data.

   // A read is decoded in its address phase so that hrdata stands for its data phase.
   // A read that meets a write still in its data phase returns the value before it.
   always_comb begin
      next_wr_pend = addr_phase && hwrite;
      next_wr_addr = addr_phase ? haddr[7:0] : wr_addr;
      next_hrdata = rst_read_data;
      if (addr_phase && !hwrite) begin
         case (haddr[7:0])
            off_trip_flag_status: begin
               next_hrdata = {29'h0, flag_one_shot, flag_cycle, flag_int};
            end
            off_event_trigger_select: next_hrdata = {16'h0, event_trigger_select};
            off_event_prescale: next_hrdata = {16'h0, count_b, period_b, count_a,
               period_a, 8'h00};
            default: next_hrdata = rst_read_data;
         endcase
      end
   end

   // Bus state registers.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= rst_read_data;
      end else begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers.

   // Select and prescale periods load whole from the written word.
   always_comb begin
      next_event_trigger_select = event_trigger_select;
      next_period_a = period_a;
      next_period_b = period_b;
      if (write_select) begin
         next_event_trigger_select = hwdata[15:0];
      end
      if (write_prescale) begin
         next_period_a = hwdata[lsb_conv_start_a_event_period +: 2];
         next_period_b = hwdata[lsb_conv_start_b_event_period +: 2];
      end
   end

   // Configuration state.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_trigger_select <= rst_event_trigger_select;
         period_a <= rst_event_prescale[1:0];
         period_b <= rst_event_prescale[3:2];
      end else begin
         event_trigger_select <= next_event_trigger_select;
         period_a <= next_period_a;
         period_b <= next_period_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Trip flags and trip interrupt.

   // Sets win over clears in the same cycle, so a trip that is still present when
   // software clears its flag is never lost; the flag simply stays set.
   always_comb begin
      next_flag_one_shot = flag_one_shot;
      if (clr_one_shot) begin
         next_flag_one_shot = 1'b0;
      end
      if (set_one_shot) begin
         next_flag_one_shot = 1'b1;
      end
      next_flag_cycle = flag_cycle;
      if (clr_cycle) begin
         next_flag_cycle = 1'b0;
      end
      if (set_cycle) begin
         next_flag_cycle = 1'b1;
      end

      // The trip condition itself is independent of the flag clear: it only drops
      // at counter zero, so the output stays safe however early software clears.
      next_cycle_latch = cycle_latch;
      if (time_base_count_zero && !cycle_by_cycle_trip_in) begin
         next_cycle_latch = 1'b0;
      end
      if (set_cycle) begin
         next_cycle_latch = 1'b1;
      end

      // One pulse per interrupt flag set; a cleared flag with trips pending rearms.
      // Looking at the next flag values lets a trip that arrives with the clear count.
      next_flag_int = flag_int;
      next_trip_irq = 1'b0;
      if (clr_int) begin
         next_flag_int = 1'b0;
      end
      if ((!flag_int || clr_int) && (next_flag_one_shot || next_flag_cycle)) begin
         next_flag_int = 1'b1;
         next_trip_irq = 1'b1;
      end
   end

   // Trip state.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_one_shot <= 1'b0;
         flag_cycle <= 1'b0;
         flag_int <= 1'b0;
         cycle_latch <= 1'b0;
         trip_irq <= 1'b0;
      end else begin
         flag_one_shot <= next_flag_one_shot;
         flag_cycle <= next_flag_cycle;
         flag_int <= next_flag_int;
         cycle_latch <= next_cycle_latch;
         trip_irq <= next_trip_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Module interrupt and converter start pulses.

   // Converter start prescalers: count events, pulse at period, then clear.
   // A disabled start still counts and clears, so enabling it mid-run keeps phase.
   always_comb begin
      next_module_irq = ev_int && event_trigger_select[bit_module_irq_enable];

      next_count_a = count_a;
      next_conv_a = 1'b0;
      if (period_a == 2'h0) begin
         next_count_a = 2'h0;
      end else if (ev_a) begin
         if (count_a + 2'h1 >= period_a) begin
            next_count_a = 2'h0;
            next_conv_a = event_trigger_select[bit_conv_start_a_enable];
         end else begin
            next_count_a = count_a + 2'h1;
         end
      end

      next_count_b = count_b;
      next_conv_b = 1'b0;
      if (period_b == 2'h0) begin
         next_count_b = 2'h0;
      end else if (ev_b) begin
         if (count_b + 2'h1 >= period_b) begin
            next_count_b = 2'h0;
            next_conv_b = event_trigger_select[bit_conv_start_b_enable];
         end else begin
            next_count_b = count_b + 2'h1;
         end
      end
   end

   // Event state; every pulse leaves a flip-flop and lasts one cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_a <= 2'h0;
         count_b <= 2'h0;
         module_irq <= 1'b0;
         conv_start_a_pulse <= 1'b0;
         conv_start_b_pulse <= 1'b0;
      end else begin
         count_a <= next_count_a;
         count_b <= next_count_b;
         module_irq <= next_module_irq;
         conv_start_a_pulse <= next_conv_a;
         conv_start_b_pulse <= next_conv_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status outputs.

   // Both levels come straight from flip-flops.
   assign one_shot_trip = flag_one_shot;
   assign cycle_by_cycle_trip_active = cycle_latch;

endmodule // trip_event_ctrl

// ### verification/pwm_trip_clear_and_event_trigger_tb.sv
/* Bench for the trip and event block: table of selections, then trip cases.
 Assumes zero-wait AHB-Lite and the far-side model. */
`timescale 1ns/1ns
module pwm_trip_clear_and_event_trigger_tb;
   import trip_event_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, os_in, cyc_in;
   logic trip_irq, irq, soc_a, soc_b, os_flag, cyc_act;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans, hresp;
   logic [2:0] hsize;
   logic [5:0] fire, ev;
   logic [7:0] n_trip;
   int n_mismatch, num_checks;
   // Rows: select value, event bits, expected {b, a, irq}.
   logic [24:0] rows [11] = '{{16'h9909, 6'h01, 3'h7}, {16'haa0a, 6'h02, 3'h7},
      {16'hcc0c, 6'h04, 3'h7}, {16'hdd0d, 6'h08, 3'h7}, {16'hee0e, 6'h10, 3'h7},
      {16'hff0f, 6'h20, 3'h7}, {16'h8808, 6'h3f, 3'h0}, {16'hbb0b, 6'h3f, 3'h0},
      {16'h1101, 6'h01, 3'h0}, {16'h9901, 6'h01, 3'h6}, {16'h9c0a, 6'h04, 3'h2}};
   ////////////////////////////////////////
   // Clock.
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   trip_event_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .one_shot_trip_in(os_in),
      .cycle_by_cycle_trip_in(cyc_in), .time_base_count_zero(ev[0]),
      .time_base_count_period(ev[1]), .compare_a_up(ev[2]), .compare_a_down(ev[3]),
      .compare_b_up(ev[4]), .compare_b_down(ev[5]), .trip_irq(trip_irq), .module_irq(irq),
      .conv_start_a_pulse(soc_a), .conv_start_b_pulse(soc_b), .one_shot_trip(os_flag),
      .cycle_by_cycle_trip_active(cyc_act));
   time_base_model u_model (.hclk(hclk), .hresetn(hresetn), .fire(fire),
      .trip_irq(trip_irq), .events(ev), .n_taken(n_trip));
   ////////////////////////////////////////
   // Compare and count.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single transfer; hrdata is taken at the edge ending the data phase.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= htrans_nonseq;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   // Fire events and look at the pulses one cycle after the block sees them.
   task automatic ev_chk(input logic [5:0] e, input logic [2:0] exp);
      fire <= e;
      @(posedge hclk);
      fire <= 6'h0;
      @(posedge hclk);
      #1;
      chk({29'h0, soc_b, soc_a, irq}, {29'h0, exp});
      @(posedge hclk);
   endtask
   // Write, then read status and the count of trip pulses.
   task automatic trip_step(input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] st, input logic [7:0] n);
      bus(1'b1, a, d, r);
      @(posedge hclk);
      bus(1'b0, off_trip_flag_status, 32'h0, r);
      chk(r, st);
      @(posedge hclk);
      chk({24'h0, n_trip}, {24'h0, n});
   endtask
   // Verdict.
   task automatic wrap_up;
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   // Main sequence.
   initial begin
      {hresetn, hsel, hwrite, os_in, cyc_in, htrans, haddr, hwdata, fire} = '0;
      hsize = 3'h2;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, off_event_trigger_select, 32'h0, r);
      chk(r, 32'h0);
      bus(1'b1, off_event_prescale, 32'h1100, r);
      foreach (rows[i]) begin
         bus(1'b1, off_event_trigger_select, {16'h0, rows[i][24:9]}, r);
         bus(1'b0, off_event_trigger_select, 32'h0, r);
         chk(r, {16'h0, rows[i][24:9]});
         ev_chk(rows[i][8:3], rows[i][2:0]);
      end
      trip_step(off_trip_software_force, 32'h4, 32'h5, 8'h1);
      chk({31'h0, os_flag}, 32'h1);
      trip_step(off_trip_software_force, 32'h2, 32'h7, 8'h1);
      trip_step(off_trip_flag_clear, 32'h1, 32'h7, 8'h2);
      trip_step(off_trip_flag_clear, 32'h0, 32'h7, 8'h2);
      trip_step(off_trip_flag_clear, 32'h4, 32'h3, 8'h2);
      chk({31'h0, os_flag}, 32'h0);
      trip_step(off_trip_flag_clear, 32'h2, 32'h1, 8'h2);
      trip_step(off_trip_flag_clear, 32'h1, 32'h0, 8'h2);
      trip_step(off_trip_software_force, 32'h1, 32'h0, 8'h2);
      bus(1'b0, off_trip_flag_clear, 32'h0, r);
      chk(r, 32'h0);
      bus(1'b0, off_trip_software_force, 32'h0, r);
      chk(r, 32'h0);
      cyc_in <= 1'b1;
      @(posedge hclk);
      cyc_in <= 1'b0;
      trip_step(off_trip_flag_clear, 32'h0, 32'h3, 8'h3);
      chk({31'h0, cyc_act}, 32'h1);
      ev_chk(6'h01, 3'h4);
      chk({31'h0, cyc_act}, 32'h0);
      // Period two: the first zero event only counts, the second fires B.
      bus(1'b1, off_event_prescale, 32'h2200, r);
      ev_chk(6'h01, 3'h0);
      bus(1'b0, off_event_prescale, 32'h0, r);
      chk(r, 32'h6200);
      ev_chk(6'h01, 3'h4);
      bus(1'b0, off_event_prescale, 32'h0, r);
      chk(r, 32'h2200);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, off_event_trigger_select, 32'h0, r);
      chk(r, 32'h0);
      wrap_up();
   end
   // Watchdog.
   initial begin
      repeat (5000) @(posedge hclk);
      n_mismatch++;
      wrap_up();
   end
endmodule // pwm_trip_clear_and_event_trigger_tb

// ### verification/time_base_model.sv
/* Far-side model: sources time-base events and counts trip pulses taken.
 Assumes the bench raises fire for one cycle per event. */
`timescale 1ns/1ns
module time_base_model (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Requests, bit 0 zero up to bit 5 compare B down, and the trip pulse.
   input wire logic [5:0] fire,
   input wire logic trip_irq,
   // Events and trip pulse count.
   output logic [5:0] events,
   output logic [7:0] n_taken
);
   logic [5:0] next_events;
   logic [7:0] next_taken;
   // Events are registered, so they follow fire one cycle later and last as long as it.
   always_comb begin
      next_events = fire;
      next_taken = n_taken + {7'h0, trip_irq};
   end
   // State.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         events <= 6'h0;
         n_taken <= 8'h0;
      end else begin
         events <= next_events;
         n_taken <= next_taken;
      end
   end
endmodule // time_base_model

// ### verification/trip_event_ctrl_props.sv
/* Checker for the trip and event block, bound to its ports.
 Assumes hready is tied to hreadyout and one clock domain. */
`timescale 1ns/1ns
module trip_event_ctrl_props
   import trip_event_pkg::*;
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Bus.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic [1:0] hresp,
   // Trip and events.
   input wire logic one_shot_trip_in,
   input wire logic cycle_by_cycle_trip_in,
   input wire logic time_base_count_zero,
   input wire logic time_base_count_period,
   input wire logic compare_a_up,
   input wire logic compare_a_down,
   input wire logic compare_b_up,
   input wire logic compare_b_down,
   // Outputs.
   input wire logic trip_irq,
   input wire logic module_irq,
   input wire logic conv_start_a_pulse,
   input wire logic conv_start_b_pulse,
   input wire logic one_shot_trip,
   input wire logic cycle_by_cycle_trip_active
);
   logic [2:0] ph;
   logic [2:0] next_ph;
   logic any_ev;
   ////////////////////////////////////////
   // Decode is held into the data phase, because hwdata only lands there.
   always_comb begin
      next_ph = 3'h0;
      if (hsel && hready && htrans == htrans_nonseq) begin
         next_ph[0] = hwrite && haddr[7:0] == off_trip_software_force;
         next_ph[1] = hwrite && haddr[7:0] == off_trip_flag_clear;
         next_ph[2] = !hwrite && (haddr[7:0] == off_trip_flag_clear
            || haddr[7:0] == off_trip_software_force);
      end
   end
   // Phase register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph <= 3'h0;
      end else begin
         ph <= next_ph;
      end
   end
   // Any time-base event this cycle.
   assign any_ev = |{time_base_count_zero, time_base_count_period, compare_a_up,
      compare_a_down, compare_b_up, compare_b_down};
   ////////////////////////////////////////
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_bus_okay: assert property (hreadyout && hresp == hresp_okay)
      else $error("Bus slave not ready or not OKAY.");
   chk_cmd_reads_zero: assert property (ph[2] |-> hrdata == 32'h0)
      else $error("Command register read not zero.");
   chk_force_sets_ost: assert property (ph[0] && hwdata[2] |=> one_shot_trip)
      else $error("Force did not set one-shot flag.");
   chk_clear_sets_low: assert property (
      ph[1] && hwdata[2] && !one_shot_trip_in |=> !one_shot_trip)
      else $error("Clear did not drop one-shot flag.");
   chk_clear_zero_keeps: assert property (
      ph[1] && !hwdata[2] && one_shot_trip |=> one_shot_trip)
      else $error("Zero clear dropped one-shot flag.");
   chk_set_has_cause: assert property ($rose(one_shot_trip) |->
      $past(one_shot_trip_in) || ($past(ph[0]) && $past(hwdata[2])))
      else $error("One-shot flag set without cause.");
   chk_latch_release: assert property ($fell(cycle_by_cycle_trip_active) |->
      $past(time_base_count_zero) && !$past(cycle_by_cycle_trip_in))
      else $error("Cycle trip latch released early.");
   chk_irq_cause: assert property (module_irq |-> $past(any_ev))
      else $error("Module interrupt without event.");
   chk_conv_cause: assert property (
      conv_start_a_pulse || conv_start_b_pulse |-> $past(any_ev))
      else $error("Converter start without event.");
   chk_trip_one_pulse: assert property (trip_irq |=> !trip_irq)
      else $error("Trip interrupt longer than one cycle.");
endmodule // trip_event_ctrl_props
bind trip_event_ctrl trip_event_ctrl_props u_props (.*);
